// ==== rtl/rpf_regs.svh ====
// register offsets, field positions and serial framing constants
`ifndef RPF_REGS_SVH
`define RPF_REGS_SVH
`define RPF_DEV_ADDR 8'hE8
`define RPF_CMD_PIN_CFG 4'h1
`define RPF_ADDR_BITS 5'h08
`define RPF_DATA_BITS 5'h10
`define RPF_CFG_RESET 8'h00
`define RPF_EMPH_USER_BIT 0
`define RPF_STAT_VALID_BIT 1
`define RPF_FLAG_CONTENT_BIT 2
`define RPF_INPUT_MON_BIT 3
`define RPF_RATE_LIM_LSB 4
`define RPF_RATE_LIM_MSB 5
`define RPF_FSYNC_LSB 6
`define RPF_FSYNC_MSB 7
`define RPF_CMD_LSB 4
`define RPF_CMD_MSB 7
`define RPF_RSVD_LSB 2
`define RPF_RSVD_MSB 3
`define RPF_CFG_LSB 8
`define RPF_CFG_MSB 15
`endif

// ==== rtl/rpf_pkg.sv ====
// types shared by the pin function configuration block
package rpf_pkg;
  typedef enum logic [1:0] {
    RPF_ST_IDLE = 2'b00,
    RPF_ST_ADDR = 2'b01,
    RPF_ST_DATA = 2'b10
  } rpf_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } rpf_sync_t;

  typedef struct packed {
    rpf_state_t state;
    logic [7:0] addr_sr;
    logic [15:0] data_sr;
    logic [4:0] cnt;
    logic ce_prev;
    logic cl_prev;
    logic [7:0] cfg;
    logic flag_pin;
    logic eus_pin;
    logic commit;
  } rpf_top_t;
endpackage

// ==== rtl/rpf_pin_sync.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module rpf_pin_sync
  import rpf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic pin_in,
  output logic level_out
);
  rpf_sync_t st_q;
  rpf_sync_t st_d;

  // level only moves once stages two and three agree
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end

  // state register
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_out = st_q.lvl;
endmodule // rpf_pin_sync

// ==== rtl/rpf_pin_cfg.sv ====
// serial-written pin function configuration with flag pin muxing
`timescale 1ns/10ps
`include "rpf_regs.svh"
module rpf_pin_cfg
  import rpf_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic ser_clk_in,
  input wire logic ser_en_in,
  input wire logic ser_data_in,
  input wire logic cs_bit1_in,
  input wire logic validity_in,
  input wire logic comp_sync_in,
  input wire logic cd_sync_in,
  input wire logic emphasis_in,
  input wire logic user_data_in,
  input wire logic cs_data_in,
  output logic channel_flag_pin_out,
  output logic emph_user_status_pin_out,
  output logic input_monitor_sel_out,
  output logic [1:0] rate_accept_limit_out,
  output logic [1:0] frame_sync_pin_sel_out
);
  rpf_top_t st_q;
  rpf_top_t st_d;
  logic [2:0] pin_raw;
  logic [2:0] pin_lvl;
  logic cl_lvl;
  logic ce_lvl;
  logic di_lvl;
  logic cl_rise;
  logic ce_rise;
  logic ce_fall;
  logic emph_user_pin_sel;
  logic status_validity_pin_sel;
  logic flag_content_sel;
  logic [1:0] frame_sync_pin_sel;
  logic cmd_ok;

  assign pin_raw = {ser_data_in, ser_en_in, ser_clk_in};

  // serial pins arrive asynchronously, so each is filtered
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      rpf_pin_sync u_sync (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .pin_in(pin_raw[gi]),
        .level_out(pin_lvl[gi])
      );
    end
  endgenerate

  // filtered levels and their edges
  assign cl_lvl = pin_lvl[0];
  assign ce_lvl = pin_lvl[1];
  assign di_lvl = pin_lvl[2];
  assign cl_rise = cl_lvl && !st_q.cl_prev;
  assign ce_rise = ce_lvl && !st_q.ce_prev;
  assign ce_fall = !ce_lvl && st_q.ce_prev;

  // decoded configuration fields
  assign emph_user_pin_sel = st_q.cfg[`RPF_EMPH_USER_BIT];
  assign status_validity_pin_sel = st_q.cfg[`RPF_STAT_VALID_BIT];
  assign flag_content_sel = st_q.cfg[`RPF_FLAG_CONTENT_BIT];
  assign frame_sync_pin_sel = st_q.cfg[`RPF_FSYNC_MSB:`RPF_FSYNC_LSB];

  // command nibble and zeroed reserved bits
  assign cmd_ok =
    (st_q.data_sr[`RPF_CMD_MSB:`RPF_CMD_LSB] == `RPF_CMD_PIN_CFG) &&
    (st_q.data_sr[`RPF_RSVD_MSB:`RPF_RSVD_LSB] == 2'h0);

  // next-state logic: serial capture and pin muxing
  always_comb begin
    st_d = st_q;
    st_d.ce_prev = ce_lvl;
    st_d.cl_prev = cl_lvl;
    st_d.commit = 1'b0;
    unique case (st_q.state)
      RPF_ST_IDLE: begin
        // a burst aimed elsewhere is skipped until enable drops
        if (ce_fall) begin
          st_d.state = RPF_ST_ADDR;
          st_d.cnt = 5'h00;
        end
      end
      RPF_ST_ADDR: begin
        // address byte shifts in lsb first while enable is low
        if (cl_rise && st_q.cnt != `RPF_ADDR_BITS) begin
          st_d.addr_sr = {di_lvl, st_q.addr_sr[7:1]};
          st_d.cnt = st_q.cnt + 5'h01;
        end
        // only address E8 opens the data phase
        if (ce_rise) begin
          st_d.cnt = 5'h00;
          if (st_q.cnt == `RPF_ADDR_BITS &&
              st_q.addr_sr == `RPF_DEV_ADDR) begin
            st_d.state = RPF_ST_DATA;
          end else begin
            st_d.state = RPF_ST_IDLE;
          end
        end
      end
      RPF_ST_DATA: begin
        // extra clocks push the count past 16 and void the write
        if (cl_rise && st_q.cnt <= `RPF_DATA_BITS) begin
          st_d.data_sr = {di_lvl, st_q.data_sr[15:1]};
          st_d.cnt = st_q.cnt + 5'h01;
        end
        // whole byte latched at end of frame
        if (ce_fall) begin
          if (st_q.cnt == `RPF_DATA_BITS && cmd_ok) begin
            st_d.cfg = st_q.data_sr[`RPF_CFG_MSB:`RPF_CFG_LSB];
            st_d.commit = 1'b1;
          end
          st_d.state = RPF_ST_ADDR;
          st_d.cnt = 5'h00;
        end
      end
      default: begin
        st_d.state = RPF_ST_IDLE;
      end
    endcase

    // status bit or validity on flag pin
    if (status_validity_pin_sel) begin
      st_d.flag_pin = validity_in;
    // content select only in status mode
    end else if (flag_content_sel) begin
      st_d.flag_pin = cs_bit1_in || comp_sync_in || cd_sync_in;
    end else begin
      st_d.flag_pin = cs_bit1_in;
    end

    if (frame_sync_pin_sel != 2'h0) begin
      st_d.eus_pin = cs_data_in;
    end else if (emph_user_pin_sel) begin
      st_d.eus_pin = user_data_in;
    end else begin
      st_d.eus_pin = emphasis_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign channel_flag_pin_out = st_q.flag_pin;
  assign emph_user_status_pin_out = st_q.eus_pin;
  assign input_monitor_sel_out = st_q.cfg[`RPF_INPUT_MON_BIT];
  assign rate_accept_limit_out = st_q.cfg[`RPF_RATE_LIM_MSB:`RPF_RATE_LIM_LSB];
  assign frame_sync_pin_sel_out = frame_sync_pin_sel;

  validity_out_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    status_validity_pin_sel |=> channel_flag_pin_out == $past(validity_in))
    else $error("flag pin does not follow validity");

  status_only_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (!status_validity_pin_sel && !flag_content_sel)
      |=> channel_flag_pin_out == $past(cs_bit1_in))
    else $error("flag pin does not follow status bit");

  content_ignored_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (status_validity_pin_sel && flag_content_sel && !validity_in)
      |=> !channel_flag_pin_out)
    else $error("content select leaked into validity mode");

  sync_high_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (!status_validity_pin_sel && flag_content_sel &&
     (comp_sync_in || cd_sync_in)) |=> channel_flag_pin_out)
    else $error("flag pin low despite sync detect");

  status_data_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (frame_sync_pin_sel != 2'h0)
      |=> emph_user_status_pin_out == $past(cs_data_in))
    else $error("shared pin not carrying status data");

  emph_default_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (frame_sync_pin_sel == 2'h0 && !emph_user_pin_sel)
      |=> emph_user_status_pin_out == $past(emphasis_in))
    else $error("shared pin not carrying emphasis");

  addr_match_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    (st_q.state == RPF_ST_ADDR && st_d.state == RPF_ST_DATA)
      |-> st_q.addr_sr == `RPF_DEV_ADDR)
    else $error("data phase opened for foreign address");

  cfg_latch_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !st_q.commit ##1 st_q.commit
      |-> st_q.cfg == $past(st_q.data_sr[`RPF_CFG_MSB:`RPF_CFG_LSB]))
    else $error("configuration byte not latched whole");

  cfg_stable_a: assert property (
    @(posedge sys_clk_in) disable iff (!resetn_in)
    !st_d.commit |=> $stable(st_q.cfg))
    else $error("configuration changed without a write");
endmodule // rpf_pin_cfg

// ==== verif/rpf_host_model.sv ====
// host model driving the serial control pins
`timescale 1ns/10ps
module rpf_host_model (
  input wire logic sys_clk_in,
  output logic ser_clk_out,
  output logic ser_en_out,
  output logic ser_data_out
);
  // enable idles high so the first fall opens an address phase
  initial begin
    ser_clk_out = 1'b0;
    ser_en_out = 1'b1;
    ser_data_out = 1'b0;
  end
  // ten clocks a level, well over the four the filter needs
  task automatic hold(input logic c);
    ser_clk_out <= c;
    repeat (10) @(posedge sys_clk_in);
  endtask
  task automatic send(input logic [23:0] w, input int n);
    ser_en_out <= 1'b0;
    for (int i = 0; i < n; i++) begin
      if (i == 8) ser_en_out <= 1'b1;
      // bits past the word wrap round, so over-long frames stay defined
      ser_data_out <= w[i % 24];
      hold(1'b0);
      hold(1'b1);
    end
    // clock stands still, data line no longer meaningful
    ser_data_out <= ~ser_data_out;
    ser_en_out <= 1'b0;
    hold(1'b0);
  endtask
endmodule // rpf_host_model

// ==== verif/testbench.sv ====
// self-checking bench for the pin function configuration block
`timescale 1ns/10ps
`include "rpf_regs.svh"
module testbench;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [6:0] src = 7'h0;
  logic ser_clk, ser_en, ser_data, flag, eus, mon;
  logic [1:0] rate, fsel;
  int fails = 0;
  int checks = 0;
  int cycles = 0;

  rpf_host_model u_host (
    .sys_clk_in(sys_clk_in),
    .ser_clk_out(ser_clk),
    .ser_en_out(ser_en),
    .ser_data_out(ser_data)
  );

  rpf_pin_cfg u_dut (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .ser_clk_in(ser_clk),
    .ser_en_in(ser_en),
    .ser_data_in(ser_data),
    .cs_bit1_in(src[6]),
    .validity_in(src[5]),
    .comp_sync_in(src[4]),
    .cd_sync_in(src[3]),
    .emphasis_in(src[2]),
    .user_data_in(src[1]),
    .cs_data_in(src[0]),
    .channel_flag_pin_out(flag),
    .emph_user_status_pin_out(eus),
    .input_monitor_sel_out(mon),
    .rate_accept_limit_out(rate),
    .frame_sync_pin_sel_out(fsel)
  );

  // free-running system clock
  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end

  task automatic conclude();
    if (fails == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard, normal run is near 11000 cycles
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      conclude();
    end
  end

  task automatic cmp(input string n, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // config outputs looked at mid-cycle, away from the launching edge
  task automatic ccfg(input logic [7:0] c);
    @(negedge sys_clk_in);
    cmp("config", {3'h0, c[7:3]}, {3'h0, fsel, rate, mon});
    @(posedge sys_clk_in);
  endtask

  // whole frame, then time for the commit to land
  task automatic wr(input logic [7:0] a, input logic [7:0] c,
                    input logic [7:0] d, input int n);
    u_host.send({d, c, a}, n);
    repeat (10) @(posedge sys_clk_in);
  endtask

  // every input pattern against the expected pin functions
  task automatic sweep(input logic [7:0] c);
    logic f, u;
    for (int v = 0; v < 128; v++) begin
      src <= v[6:0];
      repeat (2) @(posedge sys_clk_in);
      f = c[1] ? src[5] : (src[6] | (c[2] & (src[4] | src[3])));
      u = (c[7:6] != 2'h0) ? src[0] : (c[0] ? src[1] : src[2]);
      @(negedge sys_clk_in);
      cmp("flag pin", {7'h0, f}, {7'h0, flag});
      cmp("shared pin", {7'h0, u}, {7'h0, eus});
      @(posedge sys_clk_in);
    end
  endtask

  task automatic t_reset();
    ccfg(8'h00);
    sweep(8'h00);
  endtask

  task automatic t_pins();
    logic [7:0] c;
    for (int k = 0; k < 8; k++) begin
      c = {k[2:1], 3'h0, k[2:0]};
      wr(`RPF_DEV_ADDR, 8'h10, c, 24);
      sweep(c);
    end
  endtask

  task automatic t_refuse();
    wr(`RPF_DEV_ADDR, 8'h10, 8'hB8, 24);
    ccfg(8'hB8);
    wr(8'hE9, 8'h10, 8'h00, 24);
    wr(`RPF_DEV_ADDR, 8'h20, 8'h00, 24);
    wr(`RPF_DEV_ADDR, 8'h14, 8'h00, 24);
    wr(`RPF_DEV_ADDR, 8'h10, 8'h00, 23);
    wr(`RPF_DEV_ADDR, 8'h10, 8'h00, 25);
    ccfg(8'hB8);
    wr(`RPF_DEV_ADDR, 8'h13, 8'h47, 24);
    ccfg(8'h47);
  endtask

  // reset held eight cycles, then the scenarios
  initial begin
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    t_reset();
    t_pins();
    t_refuse();
    conclude();
  end
endmodule // testbench
